// [core/hb_spi_pkg.sv]
// Package: shared constants for the half-bridge serial control port
// Assumes a 250 MHz system clock on both ends
package hb_spi_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CLK_PERIOD_NS = 4;
  // Command word field positions
  localparam int BIT_STATUS_RESET = 15;
  localparam int BIT_GROUP_SELECT = 14;
  localparam int BIT_UNDERLOAD = 13;
  localparam int BIT_ENABLE_HI = 12;
  localparam int BIT_ENABLE_LO = 7;
  localparam int BIT_SIDE_HI = 6;
  localparam int BIT_SIDE_LO = 1;
  localparam int BIT_OVERVOLTAGE_LOCKOUT_ENABLE = 0;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // Timing
  localparam int SELECT_IDLE_TIME_NS = 5000;
  localparam int SELECT_IDLE_CYC = (SELECT_IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SRR_GAP_TIME_NS = 150000;
  localparam int SRR_GAP_CYC = (SRR_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_TO_SERIAL_VALID_NS = 100000;
  localparam int WAKE_CYC = WAKE_TO_SERIAL_VALID_NS / CLK_PERIOD_NS;
  localparam int POR_CYC_DEFAULT = 64;
  localparam int SCLK_HALF_CYC = 16;
  // Host register map (Avalon word addresses are byte/4)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TX = 4'h1;
  localparam logic [3:0] REG_RX = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_IRQ_STAT = 4'h4;
  localparam logic [3:0] REG_IRQ_CLR = 4'h5;
  localparam logic [3:0] REG_IRQ_EN = 4'h6;
  localparam int CTRL_GO = 0;
  localparam int CTRL_ENABLE = 1;
endpackage

// [core/hb_spi_if.sv]
// Interface: serial link between host and half-bridge port
// Resolves the tri-state serial output from its enable
`timescale 1ns/1ns
interface hb_spi_if;
  logic chip_select_n;
  logic sclk;
  logic sdi;
  logic sdo_out;
  logic sdo_oe;
  logic global_enable;
  wire sdo = sdo_oe ? sdo_out : 1'b0;
  modport device (input chip_select_n, input sclk, input sdi, input global_enable, output sdo_out, output sdo_oe);
  modport host (output chip_select_n, output sclk, output sdi, output global_enable, input sdo);
endinterface

// [core/pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
// Assumes an asynchronous input and the local clk
`timescale 1ns/1ns
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);
  logic s1_q, s2_q, s3_q;
  // Shift chain
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Level changes only when stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      level <= RESET_VAL;
    end else if (s2_q == s3_q) begin
      level <= s3_q;
    end
  end
endmodule

// [core/hb_spi_device.sv]
// Device end: serial command port of a twelve-channel half-bridge driver
// Assumes link pins from the host, sampled on clk; fault inputs are levels
// Function
// - Frames are sixteen-bit full duplex
// - Host idles select at least 5 us
// - Status-reset frames spaced 150 us apart
// - Host waits 100 us after enable
// - Enable low clears everything, drivers off
// - Enable rising runs power-on reset
// - Serial port works only when enabled
// - Thermal pseudo-bit shown until first rise
// - Host holds clock and data low first
// - Select low starts frame, output driven
// - Input shifts on rise, MSB first
// - Input recognised at falling clock edge
// - Status shifts out on rise, MSB first
// - Select high ends frame, output released
// - Good frame loads command, else discarded
// - Command register resets to zero
// - Bit 15 resets selected group faults
// - Group fields drive enables and sides
`timescale 1ns/1ns
module hb_spi_device
  import hb_spi_pkg::*;
#(
  parameter int POR_CYC = POR_CYC_DEFAULT,
  parameter int CHANNELS = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link
  hb_spi_if.device link,
  // Fault sources: overcurrent and underload one per channel, thermal and supply shared
  input wire logic [CHANNELS-1:0] overcurrent_fault,
  input wire logic [CHANNELS-1:0] underload_fault,
  input wire logic thermal_fault,
  input wire logic supply_fault,
  // Driver controls
  output logic [CHANNELS-1:0] bridge_output_enable,
  output logic [CHANNELS-1:0] bridge_side_select,
  output logic [1:0] underload_shutdown_enable,
  output logic overvoltage_lockout_enable,
  output logic awake
);
  import hb_spi_pkg::*;
  localparam int HALF = CHANNELS / 2;

  typedef enum {SLEEP, POR, RUN} pwr_t;
  pwr_t pwr_q;
  logic en_s, cs_s, sclk_s, sdi_s;
  logic cs_prev_q, sclk_prev_q;
  logic [15:0] shift_q, cmd_q, status_q;
  logic [15:0] por_cnt_q;
  logic [5:0] edges_q;
  logic sdi_hold_q, sdo_q, sdo_oe_q, in_frame_q;
  logic [CHANNELS-1:0] oc_latch_q, ul_latch_q;
  logic tsd_latch_q;
  logic cs_fall, cs_rise, sclk_rise, sclk_fall, frame_ok, srr_now;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  pin_sync #(.RESET_VAL(1'b0)) u_en (.clk(clk), .reset(reset), .pin(link.global_enable), .level(en_s));
  pin_sync #(.RESET_VAL(1'b1)) u_cs (.clk(clk), .reset(reset), .pin(link.chip_select_n), .level(cs_s));
  pin_sync #(.RESET_VAL(1'b0)) u_ck (.clk(clk), .reset(reset), .pin(link.sclk), .level(sclk_s));
  pin_sync #(.RESET_VAL(1'b0)) u_di (.clk(clk), .reset(reset), .pin(link.sdi), .level(sdi_s));

  ////////////////////////////////////////////////////////////////////////
  // Power state: sleep, power-on reset, run
  always_ff @(posedge clk) begin
    if (reset || !en_s) begin
      pwr_q <= SLEEP;
      por_cnt_q <= 16'h0000;
    end else begin
      case (pwr_q)
        SLEEP: begin
          pwr_q <= POR;
          por_cnt_q <= 16'h0000;
        end
        POR: begin
          por_cnt_q <= por_cnt_q + 16'h0001;
          if (por_cnt_q == 16'(POR_CYC - 1)) begin
            pwr_q <= RUN;
          end
        end
        RUN: pwr_q <= RUN;
        default: pwr_q <= SLEEP;
      endcase
    end
  end
  assign awake = (pwr_q == RUN);

  // Edge detectors on filtered levels
  always_ff @(posedge clk) begin
    if (reset) begin
      cs_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_prev_q <= cs_s;
      sclk_prev_q <= sclk_s;
    end
  end
  assign cs_fall = awake && cs_prev_q && !cs_s;
  assign cs_rise = in_frame_q && !cs_prev_q && cs_s;
  assign sclk_rise = in_frame_q && !cs_s && !sclk_prev_q && sclk_s;
  assign sclk_fall = in_frame_q && !cs_s && sclk_prev_q && !sclk_s;
  assign frame_ok = (edges_q >= 6'd16) && (edges_q[2:0] == 3'b000);
  assign srr_now = cs_rise && frame_ok && shift_q[BIT_STATUS_RESET];

  ////////////////////////////////////////////////////////////////////////
  // Frame receive: data recognised on fall, shifted in on rise
  always_ff @(posedge clk) begin
    if (reset || !awake) begin
      in_frame_q <= 1'b0;
      edges_q <= 6'd0;
      shift_q <= 16'h0000;
      sdi_hold_q <= 1'b0;
    end else begin
      if (cs_fall) begin
        in_frame_q <= 1'b1;
        edges_q <= 6'd0;
      end else if (cs_rise) begin
        in_frame_q <= 1'b0;
      end
      // First bit is followed while the clock idles low, then taken at each fall
      if (sclk_fall || cs_fall || (in_frame_q && edges_q == 6'd0 && !sclk_s)) begin
        sdi_hold_q <= sdi_s;
      end
      if (sclk_rise) begin
        shift_q <= {shift_q[14:0], sdi_hold_q};
        if (edges_q != 6'd63) begin
          edges_q <= edges_q + 6'd1;
        end
      end
    end
  end

  // Command register, last sixteen bits of a good frame
  always_ff @(posedge clk) begin
    if (reset || !awake) begin
      cmd_q <= CMD_RESET;
    end else if (cs_rise && frame_ok) begin
      cmd_q <= shift_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault latches; new faults win over a status reset
  always_ff @(posedge clk) begin
    if (reset || !awake) begin
      oc_latch_q <= '0;
      ul_latch_q <= '0;
      tsd_latch_q <= 1'b0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (srr_now && ((i >= HALF) == shift_q[BIT_GROUP_SELECT])) begin
          oc_latch_q[i] <= overcurrent_fault[i];
          ul_latch_q[i] <= underload_fault[i];
        end else begin
          oc_latch_q[i] <= oc_latch_q[i] | overcurrent_fault[i];
          ul_latch_q[i] <= ul_latch_q[i] | underload_fault[i];
        end
      end
      tsd_latch_q <= srr_now ? thermal_fault : (tsd_latch_q | thermal_fault);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial output: pseudo-bit at select fall, status bits on each rise
  always_ff @(posedge clk) begin
    if (reset || !awake) begin
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      status_q <= 16'h0000;
    end else if (cs_fall) begin
      sdo_oe_q <= 1'b1;
      sdo_q <= tsd_latch_q;
      status_q <= {|oc_hi_lo(cmd_q[BIT_GROUP_SELECT], oc_latch_q), supply_fault,
                   |oc_hi_lo(cmd_q[BIT_GROUP_SELECT], ul_latch_q),
                   oc_hi_lo(cmd_q[BIT_GROUP_SELECT], bridge_output_enable),
                   oc_hi_lo(cmd_q[BIT_GROUP_SELECT], bridge_side_select), 1'b0};
    end else if (cs_rise) begin
      sdo_oe_q <= 1'b0;
    end else if (sclk_rise) begin
      sdo_q <= status_q[15];
      status_q <= {status_q[14:0], 1'b0};
    end
  end
  assign link.sdo_out = sdo_q;
  assign link.sdo_oe = sdo_oe_q;

  // Select the six-channel group named by the group bit
  function automatic logic [5:0] oc_hi_lo(input logic hi, input logic [CHANNELS-1:0] v);
    oc_hi_lo = hi ? v[CHANNELS-1 -: 6] : v[5:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Driver controls per group; channels with overcurrent or thermal faults forced off
  always_ff @(posedge clk) begin
    if (reset || !awake) begin
      bridge_output_enable <= '0;
      bridge_side_select <= '0;
      underload_shutdown_enable <= 2'b00;
      overvoltage_lockout_enable <= 1'b0;
    end else begin
      if (cs_rise && frame_ok) begin
        for (int i = 0; i < HALF; i++) begin
          if (shift_q[BIT_GROUP_SELECT]) begin
            bridge_output_enable[HALF+i] <= shift_q[BIT_ENABLE_LO+i];
            bridge_side_select[HALF+i] <= shift_q[BIT_SIDE_LO+i];
          end else begin
            bridge_output_enable[i] <= shift_q[BIT_ENABLE_LO+i];
            bridge_side_select[i] <= shift_q[BIT_SIDE_LO+i];
          end
        end
        underload_shutdown_enable[shift_q[BIT_GROUP_SELECT]] <= shift_q[BIT_UNDERLOAD];
        overvoltage_lockout_enable <= shift_q[BIT_OVERVOLTAGE_LOCKOUT_ENABLE];
      end else begin
        bridge_output_enable <= bridge_output_enable & ~oc_latch_q & {CHANNELS{!tsd_latch_q}};
      end
    end
  end
endmodule

// [core/hb_spi_host.sv]
// Host end: Avalon-MM controlled master for the half-bridge serial port
// Assumes software keeps select idle and reset gaps; enforced here as well
`timescale 1ns/1ns
module hb_spi_host
  import hb_spi_pkg::*;
#(
  parameter int SRR_GAP = SRR_GAP_CYC,
  parameter int WAKE = WAKE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Interrupt
  output logic irq,
  // Link
  hb_spi_if.host link
);
  import hb_spi_pkg::*;
  typedef enum {IDLE, SETUP, LOW, HIGH, DONE} st_t;
  st_t st_q;
  logic [15:0] tx_q, rx_q, txsh_q;
  logic rx_pre_q, en_q, sdo_s, go;
  logic [4:0] bit_q;
  logic [5:0] half_q;
  logic [17:0] gap_q, srr_q, wake_q;
  logic [1:0] irq_stat_q, irq_en_q;
  logic done_ev;

  ////////////////////////////////////////////////////////////////////////
  // Serial input synchroniser
  pin_sync #(.RESET_VAL(1'b0)) u_so (.clk(clk), .reset(reset), .pin(link.sdo), .level(sdo_s));

  // Bus: one wait cycle on reads, none on writes
  logic rd_ack_q;
  always_ff @(posedge clk) begin
    if (reset) rd_ack_q <= 1'b0;
    else rd_ack_q <= read && !rd_ack_q;
  end
  assign waitrequest = read && !rd_ack_q;
  assign go = write && address == REG_CTRL && writedata[CTRL_GO] && st_q == IDLE && wake_q == '0;

  always_ff @(posedge clk) begin
    if (reset) begin
      readdata <= 32'h0000_0000;
    end else if (read) begin
      case (address)
        REG_CTRL: readdata <= {30'h0, en_q, st_q != IDLE};
        REG_TX: readdata <= {16'h0, tx_q};
        REG_RX: readdata <= {15'h0, rx_pre_q, rx_q};
        REG_STATUS: readdata <= {29'h0, srr_q != '0, gap_q != '0, wake_q != '0};
        REG_IRQ_STAT: readdata <= {30'h0, irq_stat_q};
        REG_IRQ_EN: readdata <= {30'h0, irq_en_q};
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_q <= 16'h0000;
      en_q <= 1'b0;
      irq_en_q <= 2'b00;
    end else if (write) begin
      if (address == REG_TX) tx_q <= writedata[15:0];
      if (address == REG_CTRL) en_q <= writedata[CTRL_ENABLE];
      if (address == REG_IRQ_EN) irq_en_q <= writedata[1:0];
    end
  end

  // Interrupt status: bit0 frame done, bit1 thermal pseudo-bit seen; set wins
  always_ff @(posedge clk) begin
    if (reset) irq_stat_q <= 2'b00;
    else irq_stat_q <= (irq_stat_q & ~((write && address == REG_IRQ_CLR) ? writedata[1:0] : 2'b00))
                       | {done_ev & rx_pre_q, done_ev};
  end
  assign irq = |(irq_stat_q & irq_en_q);

  ////////////////////////////////////////////////////////////////////////
  // Wake, idle and status-reset spacing timers
  always_ff @(posedge clk) begin
    if (reset || !en_q) wake_q <= 18'(WAKE);
    else if (wake_q != '0) wake_q <= wake_q - 18'd1;
    if (reset) begin
      gap_q <= '0;
      srr_q <= '0;
    end else begin
      if (done_ev) gap_q <= 18'(SELECT_IDLE_CYC);
      else if (gap_q != '0) gap_q <= gap_q - 18'd1;
      if (done_ev && txsh_q[BIT_STATUS_RESET]) srr_q <= 18'(SRR_GAP);
      else if (srr_q != '0) srr_q <= srr_q - 18'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame engine: clock and data low before select falls
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= IDLE;
      bit_q <= 5'd0;
      half_q <= 6'd0;
      txsh_q <= 16'h0000;
      rx_q <= 16'h0000;
      rx_pre_q <= 1'b0;
      done_ev <= 1'b0;
    end else begin
      done_ev <= 1'b0;
      case (st_q)
        IDLE: if (go && gap_q == '0 && !(tx_q[BIT_STATUS_RESET] && srr_q != '0)) begin
          st_q <= SETUP;
          txsh_q <= tx_q;
          half_q <= 6'd0;
          bit_q <= 5'd0;
        end
        SETUP: begin
          half_q <= half_q + 6'd1;
          if (half_q == 6'(SCLK_HALF_CYC - 1)) begin
            rx_pre_q <= sdo_s;
            half_q <= 6'd0;
            st_q <= HIGH;
          end
        end
        HIGH: begin
          half_q <= half_q + 6'd1;
          if (half_q == 6'(SCLK_HALF_CYC - 1)) begin
            half_q <= 6'd0;
            st_q <= LOW;
          end
        end
        LOW: begin
          half_q <= half_q + 6'd1;
          // Next bit goes out just after the rise, so it stands at the fall
          if (half_q == 6'd0) begin
            txsh_q <= {txsh_q[14:0], txsh_q[15]};
          end
          if (half_q == 6'(SCLK_HALF_CYC - 1)) begin
            half_q <= 6'd0;
            rx_q <= {rx_q[14:0], sdo_s};
            bit_q <= bit_q + 5'd1;
            st_q <= (bit_q == 5'(FRAME_BITS - 1)) ? DONE : HIGH;
          end
        end
        DONE: begin
          st_q <= IDLE;
          done_ev <= 1'b1;
        end
        default: st_q <= IDLE;
      endcase
    end
  end

  // Pin drive: clock high in LOW phase, data low while select falls
  always_ff @(posedge clk) begin
    if (reset) begin
      link.chip_select_n <= 1'b1;
      link.sclk <= 1'b0;
      link.sdi <= 1'b0;
      link.global_enable <= 1'b0;
    end else begin
      link.global_enable <= en_q;
      link.chip_select_n <= !(st_q == SETUP || st_q == HIGH || st_q == LOW);
      link.sclk <= (st_q == HIGH) ? 1'b0 : (st_q == LOW && half_q != 6'(SCLK_HALF_CYC - 1)) ? 1'b1 : 1'b0;
      link.sdi <= ((st_q == SETUP && half_q != 6'd0) || st_q == LOW || st_q == HIGH) ? txsh_q[15] : 1'b0;
    end
  end
endmodule

// [dv/hb_spi_monitor.sv]
// Checker: concurrent properties on the serial link between host and device ends
// Assumes plain link signals sampled on the shared system clock
`timescale 1ns/1ns
module hb_spi_monitor
  import hb_spi_pkg::*;
#(
  parameter int SRR_GAP = SRR_GAP_CYC,
  parameter int WAKE = WAKE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link signals
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic global_enable,
  input wire logic sdo
);
  int idle_q;
  int wake_q;
  int gap_q;
  int rises_q;
  logic sclk_q;
  logic srr_take;

  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // Previous serial clock level, for edge finding
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
  end
  // First bit of a frame asks for a status reset
  assign srr_take = !chip_select_n && sclk && !sclk_q && rises_q == 0 && sdi;
  // Cycles with select high, saturating
  always_ff @(posedge clk) begin
    idle_q <= reset ? SELECT_IDLE_CYC : (chip_select_n ? (idle_q < SELECT_IDLE_CYC ? idle_q + 1 : idle_q) : 0);
  end
  // Cycles since enable rose, saturating
  always_ff @(posedge clk) begin
    wake_q <= (reset || !global_enable) ? 0 : (wake_q < WAKE ? wake_q + 1 : wake_q);
  end
  // Cycles since the last status-reset frame began
  always_ff @(posedge clk) begin
    gap_q <= reset ? SRR_GAP : (srr_take ? 0 : (gap_q < SRR_GAP ? gap_q + 1 : gap_q));
  end
  // Rising serial clock edges within the current frame
  always_ff @(posedge clk) begin
    rises_q <= (reset || chip_select_n) ? 0 : ((sclk && !sclk_q) ? rises_q + 1 : rises_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  a_select_idle: assert property ($fell(chip_select_n) |-> idle_q >= SELECT_IDLE_CYC)
    else $error("select idle gap too short");
  a_wake_wait: assert property ($fell(chip_select_n) |-> wake_q >= WAKE)
    else $error("frame started too soon after enable");
  a_srr_gap: assert property (srr_take |-> gap_q >= SRR_GAP)
    else $error("status reset frames too close");
  a_quiet_start: assert property ($fell(chip_select_n) |-> !sclk && !sdi)
    else $error("clock or data high at frame start");
  a_sixteen_rises: assert property ($rose(chip_select_n) |-> rises_q == FRAME_BITS)
    else $error("frame did not carry sixteen clocks");
  a_data_hold: assert property (!chip_select_n && !sclk && !$past(sclk) && rises_q != 0 |-> $stable(sdi))
    else $error("data moved while clock low");
  a_drive_start: assert property ($fell(chip_select_n) && global_enable |-> ##[1:50] sdo_oe)
    else $error("serial output not driven after select");
  a_release_end: assert property ($rose(chip_select_n) |-> ##[1:50] (!sdo_oe && !sdo))
    else $error("serial output not released after select");
  a_sleep_quiet: assert property (!global_enable [*8] |-> !sdo_oe)
    else $error("serial output driven while disabled");
  a_pseudo_hold: assert property (
    sdo_oe && $past(sdo_oe) && !chip_select_n && rises_q == 0 && !sclk |-> $stable(sdo_out))
    else $error("pseudo bit changed before first clock");
endmodule

// [dv/half_bridge_spi_control_port_tb_top.sv]
// Testbench: host and device ends joined, plus a bench-driven second device
// Assumes the package, interface, both ends and the checker compiled first
`timescale 1ns/1ns
module half_bridge_spi_control_port_tb_top;
  import hb_spi_pkg::*;
  localparam int GAP_T = 3000;
  localparam int WAKE_T = 50;
  localparam logic [15:0] CMDS [2] = '{16'h6ACB, 16'h15A6};
  localparam int RAW_N [5] = '{16, 12, 24, 20, 8};
  localparam logic [23:0] RAW_D [5] = '{24'h00_6ACB, 24'h00_0FFF, 24'hA5_15A6, 24'h0F_7FFE, 24'h00_00FF};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata, rdv, rx;
  logic waitrequest, irq, ov, ov2, awake, awake2;
  logic [11:0] oc_f = 12'h000;
  logic [11:0] ul_f = 12'h000;
  logic th_f = 1'b0;
  logic sup_f = 1'b0;
  logic [11:0] be, bs, be2, bs2;
  logic [1:0] ue, ue2;
  logic [26:0] em, em2;
  int failures = 0;
  int n_checks = 0;
  int i;
  hb_spi_if link();
  hb_spi_if link2();

  ////////////////////////////////////////////////////////////////////////////
  // Ends under test, second device on a bench-driven link
  hb_spi_host #(.SRR_GAP(GAP_T), .WAKE(WAKE_T)) i_hb_spi_host (.clk(clk), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .irq(irq), .link(link));
  hb_spi_device #(.POR_CYC(32)) i_hb_spi_device (.clk(clk), .reset(reset), .link(link),
    .overcurrent_fault(oc_f), .underload_fault(ul_f), .thermal_fault(th_f), .supply_fault(sup_f),
    .bridge_output_enable(be), .bridge_side_select(bs), .underload_shutdown_enable(ue),
    .overvoltage_lockout_enable(ov), .awake(awake));
  hb_spi_device #(.POR_CYC(32)) i_hb_spi_device2 (.clk(clk), .reset(reset), .link(link2),
    .overcurrent_fault(12'h000), .underload_fault(ul_f), .thermal_fault(1'b0), .supply_fault(sup_f),
    .bridge_output_enable(be2), .bridge_side_select(bs2), .underload_shutdown_enable(ue2),
    .overvoltage_lockout_enable(ov2), .awake(awake2));
  hb_spi_monitor #(.SRR_GAP(GAP_T), .WAKE(WAKE_T)) i_hb_spi_monitor (.clk(clk), .reset(reset),
    .chip_select_n(link.chip_select_n), .sclk(link.sclk), .sdi(link.sdi), .sdo_out(link.sdo_out),
    .sdo_oe(link.sdo_oe), .global_enable(link.global_enable), .sdo(link.sdo));

  // System clock, 4 ns
  initial begin
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expected driver fields {underload[1:0], lockout, enables, sides} after a command
  function automatic logic [26:0] upd(input logic [26:0] p, input logic [15:0] c);
    logic [26:0] r;
    r = p;
    if (c[14]) begin
      r[23:18] = c[12:7];
      r[11:6] = c[6:1];
    end else begin
      r[17:12] = c[12:7];
      r[5:0] = c[6:1];
    end
    r[25 + c[14]] = c[13];
    r[24] = c[0];
    return r;
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic [3:0] a, input logic rd, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge clk);
    address <= a;
    read <= rd;
    write <= ~rd;
    writedata <= d;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (k == 50) begin
      failures++;
      complete_run();
    end
  endtask

  // Host frame: idle gap, load command, start, poll done, fetch reply
  task automatic frame(input logic [15:0] c, input logic ok);
    int k;
    repeat (SELECT_IDLE_CYC + 8) @(posedge clk);
    bus(REG_TX, 1'b0, {16'h0000, c}, rdv);
    bus(REG_CTRL, 1'b0, 32'h0000_0003, rdv);
    for (k = 0; k < 300; k++) begin
      bus(REG_IRQ_STAT, 1'b1, 32'h0000_0000, rdv);
      if (rdv[0]) break;
    end
    check("frame done", {31'h0, ok}, {31'h0, rdv[0]});
    if (ok && k == 300) complete_run();
    if (ok) begin
      bus(REG_RX, 1'b1, 32'h0000_0000, rx);
      bus(REG_IRQ_CLR, 1'b0, 32'h0000_0001, rdv);
    end
  endtask

  // Bench-made frame of n clocks on the second link, clock period near 125 ns
  task automatic raw(input int n, input logic [23:0] d);
    int k;
    @(posedge clk);
    link2.chip_select_n <= 1'b0;
    repeat (31) @(posedge clk);
    for (k = n - 1; k >= 0; k--) begin
      link2.sdi <= d[k];
      repeat (15) @(posedge clk);
      link2.sclk <= 1'b1;
      repeat (16) @(posedge clk);
      link2.sclk <= 1'b0;
    end
    repeat (16) @(posedge clk);
    link2.chip_select_n <= 1'b1;
    link2.sdi <= 1'b0;
    repeat (SELECT_IDLE_CYC) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    link2.chip_select_n = 1'b1;
    link2.sclk = 1'b0;
    link2.sdi = 1'b0;
    link2.global_enable = 1'b0;
    em = '0;
    em2 = '0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("reset outputs", 32'h0, {5'h00, ue, ov, be, bs});
    check("reset sdo enable", 32'h0, {31'h0, link.sdo_oe});
    bus(4'hF, 1'b0, 32'hFFFF_FFFF, rdv);
    bus(REG_IRQ_EN, 1'b1, 32'h0000_0000, rdv);
    check("irq enable", 32'h0, rdv);
    $display("Test reset done");
    bus(REG_CTRL, 1'b0, 32'h0000_0002, rdv);
    link2.global_enable <= 1'b1;
    repeat (WAKE_T + 64) @(posedge clk);
    check("awake", 32'h1, {31'h0, awake});
    for (i = 0; i < 2; i++) begin
      frame(CMDS[i], 1'b1);
      em = upd(em, CMDS[i]);
      check("outputs", {5'h00, em}, {5'h00, ue, ov, be, bs});
      check("reply top bits", 32'h0, {30'h0, rx[16:15]});
    end
    $display("Test commands done");
    oc_f <= 12'h001;
    repeat (20) @(posedge clk);
    oc_f <= 12'h000;
    frame(16'h15A6, 1'b1);
    check("overcurrent flag", 32'h1, {31'h0, rx[15]});
    frame(16'h95A6, 1'b1);
    frame(16'h95A6, 1'b0);
    frame(16'h95A6, 1'b1);
    frame(16'h15A6, 1'b1);
    check("overcurrent cleared", 32'h0, {31'h0, rx[15]});
    check("outputs again", {5'h00, em}, {5'h00, ue, ov, be, bs});
    $display("Test status reset done");
    th_f <= 1'b1;
    sup_f <= 1'b1;
    ul_f <= 12'h001;
    repeat (20) @(posedge clk);
    th_f <= 1'b0;
    ul_f <= 12'h000;
    frame(16'h15A6, 1'b1);
    sup_f <= 1'b0;
    check("thermal bit", 32'h1, {31'h0, rx[16]});
    check("supply and underload bits", 32'h3, {30'h0, rx[14:13]});
    check("irq masked", 32'h0, {31'h0, irq});
    bus(REG_IRQ_EN, 1'b0, 32'h0000_0002, rdv);
    @(posedge clk);
    check("irq raised", 32'h1, {31'h0, irq});
    bus(REG_IRQ_CLR, 1'b0, 32'h0000_0002, rdv);
    @(posedge clk);
    check("irq cleared", 32'h0, {31'h0, irq});
    bus(REG_IRQ_STAT, 1'b1, 32'h0000_0000, rdv);
    check("irq status", 32'h0, rdv);
    $display("Test interrupts done");
    bus(REG_CTRL, 1'b0, 32'h0000_0000, rdv);
    repeat (16) @(posedge clk);
    check("sleep outputs", 32'h0, {5'h00, ue, ov, be, bs});
    check("sleep awake", 32'h0, {31'h0, awake});
    $display("Test sleep done");
    for (i = 0; i < 5; i++) begin
      raw(RAW_N[i], RAW_D[i]);
      if (RAW_N[i] >= 16 && RAW_N[i] % 8 == 0) em2 = upd(em2, RAW_D[i][15:0]);
      check("raw frame outputs", {5'h00, em2}, {5'h00, ue2, ov2, be2, bs2});
    end
    $display("Test frame errors done");
    complete_run();
  end
endmodule
